// ### core/eprom_host.sv
// Host controller that drives a UV-erasable byte memory through its pins
// Notes on behaviour
// R1: Seven modes come from the control pin mix
// R2: Data appears only with select and gate low
// R3: Device select governs power and selection
// R4: Output gate only controls pin driving
// R5: Select high puts device in standby
// R6: Standby floats outputs whatever the gate
// R7: Identifier needs high level, select/gate low
// R8: Erased cells read as all ones
// R9: Programming clears only the zero bits
// R10: Zeros never return to one electrically
// R11: Program needs supply raised, select, strobe low
// R12: Host drives all eight data bits when programming
// R13: Only one decoded device selected at once
// R14: Output gate follows the read strobe
// R15: Verify by readback with supply still raised
// R16: High select or strobe inhibits programming
// R17: Lowest address picks maker or part code
// R18: Identifier bytes carry odd parity, top bit
// R19: Gate high while programming, low for verify
// R20: High levels are separate qualifier signals
`timescale 1ns/1ps
module eprom_host
  import eprom_host_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC     // Program pulse length
) (
  input  wire logic                               i_clk,   // 10 MHz clock
  input  wire logic                               i_rst,   // Sync reset
  input  wire logic                               i_cmd_valid, // Request
  input  wire eprom_host_pkg::cmd_t               i_cmd,   // Request fields
  output logic                                    o_ready, // Can accept
  output logic                                    o_done,  // Op finished
  output logic [eprom_host_pkg::DATA_W-1:0]       o_rdata, // Byte read
  output logic                                    o_verify_ok, // Match
  output logic                                    o_blank, // Read all ones
  output logic                                    o_stuck_zero, // 0 vs 1
  output logic                                    o_id_parity_ok, // Odd
  output eprom_host_pkg::pins_t                   o_pins,  // Control pins
  output logic [eprom_host_pkg::DATA_W-1:0]       o_data_out, // Data drive
  output logic                                    o_data_oe, // Data enable
  input  wire logic [eprom_host_pkg::DATA_W-1:0]  i_data_in  // Data pins
);
  import eprom_host_pkg::*;

  // One-hot sequencer states
  typedef enum logic [5:0] {
    S_IDLE    = 6'h01,  // Device in standby, waiting
    S_SETUP   = 6'h02,  // Address and levels settling
    S_ACCESS  = 6'h04,  // Waiting for data; gate high in first program wait
    S_PULSE   = 6'h08,  // Program strobe low
    S_RECOVER = 6'h10,  // Strobe released, data released
    S_DONE    = 6'h20   // Report and return to standby
  } state_t;

  state_t            state_q, state_d;      // Sequencer
  cmd_t              cmd_q, cmd_d;          // Latched request
  logic [CNT_W-1:0]  cnt_q, cnt_d;          // Wait counter
  pins_t             pins_q, pins_d;        // Control pins
  logic [DATA_W-1:0] dout_q, dout_d;        // Data driven out
  logic              oe_q, oe_d;            // Data driver enable
  logic [DATA_W-1:0] rdata_q, rdata_d;      // Captured byte
  logic              ready_q, ready_d;      // Accepting
  logic              done_q, done_d;        // Finished pulse
  logic              vok_q, vok_d;          // Verify match
  logic              blank_q, blank_d;      // All ones read
  logic              stuck_q, stuck_d;      // Zero where one wanted
  logic              par_q, par_d;          // Identifier parity good
  logic [DATA_W-1:0] din_sync;              // Synchronised data pins

  // Data pins come from another domain: two flops first
  byte_sync #(.W(DATA_W)) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_data_in),
    .o_sync  (din_sync)
  );

  // Sequencer next-state and pin levels
  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    cnt_d   = cnt_q;
    pins_d  = pins_q;
    dout_d  = dout_q;
    oe_d    = oe_q;
    rdata_d = rdata_q;
    ready_d = ready_q;
    done_d  = 1'b0;
    vok_d   = vok_q;
    blank_d = blank_q;
    stuck_d = stuck_q;
    par_d   = par_q;
    unique case (state_q)
      S_IDLE: begin
        // Only this device is selected; others are the user's concern
        if (i_cmd_valid) begin  // R13
          cmd_d   = i_cmd;
          ready_d = 1'b0;
          cnt_d   = SETUP_WAIT;
          pins_d.addr         = i_cmd.addr;
          pins_d.dev_select_n = 1'b0;  // R3
          unique case (i_cmd.op)
            OP_IDENT: begin
              // All lines low except the byte select line
              pins_d.addr = ADDR_ZERO;  // R17
              pins_d.addr[ID_BYTE_SEL_BIT] =
                i_cmd.addr[ID_BYTE_SEL_BIT];  // R17
              pins_d.id_high_voltage_level = 1'b1;  // R7 R20
            end
            OP_PROGRAM: begin
              // Supply up, gate high, byte driven as a whole
              pins_d.vpp_prog = 1'b1;  // R11 R20
              dout_d = i_cmd.data;     // R12
              oe_d   = 1'b1;           // R12 R19
            end
            default: begin
              // Plain read or unused code: read levels only
            end
          endcase
          state_d = S_SETUP;
        end
      end
      S_SETUP: begin
        if (cnt_q == CNT_ZERO) begin
          if (cmd_q.op == OP_PROGRAM) begin
            pins_d.program_strobe_n = 1'b0;  // R11
            cnt_d   = CNT_W'(PULSE_CYCLES - 1);
            state_d = S_PULSE;
          end else begin
            pins_d.out_gate_n = 1'b0;  // R2 R14
            cnt_d   = ACCESS_WAIT;
            state_d = S_ACCESS;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      S_PULSE: begin
        if (cnt_q == CNT_ZERO) begin
          pins_d.program_strobe_n = 1'b1;  // R16
          state_d = S_RECOVER;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      S_RECOVER: begin
        // Release data before gating the device onto the pins
        oe_d    = 1'b0;  // R19
        cnt_d   = ACCESS_WAIT;
        state_d = S_ACCESS;
      end
      S_ACCESS: begin
        // Supply stays raised here when verifying
        if (cnt_q == CNT_ZERO) begin
          // Program: first wait lets the data driver let go, second
          // is the verify read with the supply still raised
          if (cmd_q.op == OP_PROGRAM && pins_q.out_gate_n) begin
            pins_d.out_gate_n = 1'b0;  // R15 R19
            cnt_d = ACCESS_WAIT;
          end else begin
            rdata_d = din_sync;  // R2
            pins_d.out_gate_n = 1'b1;  // R4
            state_d = S_DONE;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      S_DONE: begin
        // Back to standby; outputs of the device float
        pins_d  = PINS_STANDBY;  // R5 R6
        done_d  = 1'b1;
        ready_d = 1'b1;
        blank_d = (rdata_q == BLANK_BYTE);  // R8
        vok_d   = (cmd_q.op == OP_PROGRAM) && (rdata_q == cmd_q.data);  // R15
        // A one asked for over a programmed zero cannot come back
        stuck_d = (cmd_q.op == OP_PROGRAM) &&
                  ((cmd_q.data & ~rdata_q) != '0);  // R9 R10
        par_d   = ^rdata_q;  // R18
        state_d = S_IDLE;
      end
      default: begin
        // Illegal one-hot code: park safely
        pins_d  = PINS_STANDBY;
        oe_d    = 1'b0;
        ready_d = 1'b1;
        state_d = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      cmd_q   <= '0;
      cnt_q   <= '0;
      pins_q  <= PINS_STANDBY;  // R5
      dout_q  <= '0;
      oe_q    <= 1'b0;
      rdata_q <= '0;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
      vok_q   <= 1'b0;
      blank_q <= 1'b0;
      stuck_q <= 1'b0;
      par_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      cnt_q   <= cnt_d;
      pins_q  <= pins_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      done_q  <= done_d;
      vok_q   <= vok_d;
      blank_q <= blank_d;
      stuck_q <= stuck_d;
      par_q   <= par_d;
    end
  end

  // Every output straight from a flop
  assign o_pins         = pins_q;
  assign o_data_out     = dout_q;
  assign o_data_oe      = oe_q;
  assign o_rdata        = rdata_q;
  assign o_ready        = ready_q;
  assign o_done         = done_q;
  assign o_verify_ok    = vok_q;
  assign o_blank        = blank_q;
  assign o_stuck_zero   = stuck_q;
  assign o_id_parity_ok = par_q;

  // Helper: length of the current strobe-low stretch
  int low_len_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || pins_q.program_strobe_n) begin
      low_len_q <= 0;
    end else begin
      low_len_q <= low_len_q + 1;
    end
  end

  localparam int DONE_MAX = 40;  // Bound for non-program operations

  // All checks run on the system clock and rest during reset
  default clocking cb_sys @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence seq_verify_start;
    ##[1:8] !pins_q.out_gate_n;
  endsequence

  AST_GATE_NEEDS_SELECT: assert property ( // R2
    !pins_q.out_gate_n |-> !pins_q.dev_select_n && !oe_q)
    else $error("gate low without select or with data driven");
  AST_PROGRAM_LEVELS: assert property ( // R11
    !pins_q.program_strobe_n |-> pins_q.vpp_prog && !pins_q.dev_select_n
      && pins_q.out_gate_n && oe_q)
    else $error("program strobe without programming levels");
  AST_IDENT_LEVELS: assert property ( // R7
    pins_q.id_high_voltage_level |-> !pins_q.vpp_prog
      && pins_q.program_strobe_n && !pins_q.dev_select_n)
    else $error("identifier level with wrong companions");
  AST_PULSE_WIDTH: assert property ( // R16
    $rose(pins_q.program_strobe_n) |-> low_len_q == PULSE_CYCLES)
    else $error("program pulse length wrong");
  AST_VERIFY_FOLLOWS: assert property ( // R15
    $rose(pins_q.program_strobe_n) |-> pins_q.vpp_prog throughout
      seq_verify_start)
    else $error("verify not done with supply raised");
  AST_IDLE_STANDBY: assert property ( // R5
    ready_q |-> pins_q.dev_select_n && pins_q.out_gate_n && !oe_q
      && !pins_q.vpp_prog)
    else $error("idle host leaves device selected");
  AST_READ_FINISHES: assert property ( // R1
    ready_q && i_cmd_valid && i_cmd.op != OP_PROGRAM |->
      ##[2:DONE_MAX] done_q)
    else $error("read or identify did not finish");
  AST_ID_ADDR: assert property ( // R17
    pins_q.id_high_voltage_level |->
      (pins_q.addr >> (ID_BYTE_SEL_BIT + 1)) == ADDR_ZERO)
    else $error("identifier mode with upper address lines high");
  AST_PARITY_FLAG: assert property ( // R18
    done_q |-> o_id_parity_ok == ^$past(rdata_q))
    else $error("parity flag disagrees with byte");
endmodule // eprom_host

// ### core/eprom_host_pkg.sv
// Shared constants and carrier types for the memory-programmer host
package eprom_host_pkg;
  localparam int ADDR_W          = 14;      // Address lines on the device
  localparam int DATA_W          = 8;       // Byte-wide data pins
  localparam int CNT_W           = 24;      // Wait counter width
  localparam int CLK_NS          = 100;     // Period of i_clk
  localparam int T_ACCESS_NS     = 300;     // Slowest access time
  localparam int T_SETUP_NS      = 2000;    // Address/data setup before strobe
  localparam int T_PULSE_NS      = 1000000; // One program pulse, 1 ms
  localparam int SYNC_STAGES     = 2;       // Flops on the returning data
  localparam int ID_BYTE_SEL_BIT = 0;       // id_byte_select_line position
  localparam int ID_HV_LINE_BIT  = 9;       // id_high_voltage_line position
  // Least times round up to whole cycles
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] ACCESS_WAIT = CNT_W'(ACCESS_CYC + SYNC_STAGES);
  localparam logic [CNT_W-1:0] SETUP_WAIT  = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO    = '0;
  localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);
  localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hff; // Erased cells read ones
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = '0;

  // Host operations
  typedef enum logic [1:0] {
    OP_READ    = 2'h0,  // Plain read
    OP_IDENT   = 2'h1,  // Identifier byte readout
    OP_PROGRAM = 2'h2   // Program pulse followed by verify
  } op_t;

  // One request from the user side
  typedef struct packed {
    op_t               op;    // Operation
    logic [ADDR_W-1:0] addr;  // Byte address
    logic [DATA_W-1:0] data;  // Byte to program
  } cmd_t;

  // Control pins toward the device
  typedef struct packed {
    logic [ADDR_W-1:0] addr;                  // Address lines
    logic              dev_select_n;          // Device select, low active
    logic              out_gate_n;            // Output gate, low active
    logic              program_strobe_n;      // Program strobe, low active
    logic              vpp_prog;              // Programming supply raised
    logic              id_high_voltage_level; // High level on id line
  } pins_t;

  localparam pins_t PINS_STANDBY = '{addr: '0, dev_select_n: 1'b1,
    out_gate_n: 1'b1, program_strobe_n: 1'b1, vpp_prog: 1'b0,
    id_high_voltage_level: 1'b0};
endpackage

// ### core/byte_sync.sv
// Two-flop synchroniser for the byte coming back from the device pins
`timescale 1ns/1ps
module byte_sync #(
  parameter int W = 8                 // Width of the bus
) (
  input  wire logic         i_clk,    // System clock
  input  wire logic         i_rst,    // Synchronous reset, high
  input  wire logic [W-1:0] i_async,  // Unsynchronised pins
  output logic      [W-1:0] o_sync    // Safe copy
);
  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] meta_d;  // Next first stage
  logic [W-1:0] sync_q;  // Second stage
  logic [W-1:0] sync_d;  // Next second stage

  // Next values
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // Registers; reset loads constants only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule // byte_sync

// ### sim/eprom_model.sv
// Behavioural model of the byte-wide erasable memory on the host's pins
`timescale 1ns/1ps
module eprom_model
  import eprom_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h7f, // Arbitrary value, odd parity
  parameter logic [7:0] DEVICE_CODE = 8'h2a, // Arbitrary value, odd parity
  parameter int         ACC_NS      = 250    // Output delay, under 300 ns
) (
  input  wire eprom_host_pkg::pins_t             i_pins, // Host control pins
  input  wire logic [eprom_host_pkg::DATA_W-1:0] i_hdata, // Host data drive
  input  wire logic                              i_hoe,   // Host drives
  output logic      [eprom_host_pkg::DATA_W-1:0] o_wire   // Resolved pins
);
  logic [DATA_W-1:0] mem [2**ADDR_W]; // Cell array
  logic [DATA_W-1:0] val, val_late;   // Byte offered, and after delay
  logic [DATA_W-1:0] last;            // Last driven level
  logic              sel, rd, rd_late, drive; // Mode decode

  // Blank part at power up
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) mem[i] = BLANK_BYTE;
    last = 8'h00;
  end

  // Mode decode, raised levels come as qualifiers
  assign sel = !i_pins.dev_select_n;
  // Read, verify and identifier all drive the pins
  assign rd  = sel && !i_pins.out_gate_n
               && i_pins.program_strobe_n;
  // Identifier byte picked by the lowest address line
  assign val = i_pins.id_high_voltage_level ?
    (i_pins.addr[0] ? DEVICE_CODE : MAKER_CODE) : mem[i_pins.addr];
  assign #(ACC_NS) rd_late  = rd;
  assign #(ACC_NS) val_late = val;
  // Turns off at once, on only after the access delay
  assign drive = rd && rd_late;

  // Released pins show a changed level, never the old byte
  always_comb begin
    if (i_hoe && drive) o_wire = 'x;          // Contention
    else if (i_hoe)     o_wire = i_hdata;
    else if (drive)     o_wire = val_late;
    else                o_wire = ~last;
  end

  // Remember what was last driven for the float pattern
  always @(o_wire) begin
    if (i_hoe || drive) last = o_wire;
  end

  // Cells only lose ones; select or strobe high inhibits
  always @(posedge i_pins.program_strobe_n) begin
    if (sel && i_pins.vpp_prog
        && i_pins.out_gate_n && i_hoe) begin
      mem[i_pins.addr] = mem[i_pins.addr] & i_hdata;
    end
  end
endmodule // eprom_model

// ### sim/testbench.sv
// Self-checking bench for the host controller against the memory model
`timescale 1ns/1ps
module testbench;
  import eprom_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h7f; // Arbitrary value
  localparam logic [7:0] DEVC  = 8'h2a; // Arbitrary value
  typedef struct packed {
    op_t op; logic [13:0] a; logic [7:0] d; logic [7:0] rd;
    logic vok; logic blank; logic stuck;
  } row_t;
  // Ordinary cases: request, then expected outcome
  localparam row_t ROWS [9] = '{
    '{OP_READ,    14'h0005, 8'h00, 8'hff, 1'b0, 1'b1, 1'b0},
    '{OP_PROGRAM, 14'h0005, 8'h5a, 8'h5a, 1'b1, 1'b0, 1'b0},
    '{OP_READ,    14'h0005, 8'h00, 8'h5a, 1'b0, 1'b0, 1'b0},
    '{OP_PROGRAM, 14'h0005, 8'hff, 8'h5a, 1'b0, 1'b0, 1'b1},
    '{OP_PROGRAM, 14'h0005, 8'h0f, 8'h0a, 1'b0, 1'b0, 1'b1},
    '{OP_IDENT,   14'h3ffe, 8'h00, MAKER, 1'b0, 1'b0, 1'b0},
    '{OP_IDENT,   14'h0001, 8'h00, DEVC,  1'b0, 1'b0, 1'b0},
    '{OP_PROGRAM, 14'h3fff, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
    '{OP_READ,    14'h3ffe, 8'h00, 8'hff, 1'b0, 1'b1, 1'b0}};

  logic        clk, rst, valid;   // Clock, reset, request
  cmd_t        cmd;               // Request fields
  logic        ready, done, vok, blank, stuck, par; // Status
  logic [7:0]  rdata, dout, wire_v; // Data paths
  logic        oe;                // Host data enable
  pins_t       pins;              // Control pins
  int          mismatches, total_checks, ver_n; // Tallies

  eprom_host #(.PULSE_CYCLES(8)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_cmd_valid(valid), .i_cmd(cmd),
    .o_ready(ready), .o_done(done), .o_rdata(rdata), .o_verify_ok(vok),
    .o_blank(blank), .o_stuck_zero(stuck), .o_id_parity_ok(par),
    .o_pins(pins), .o_data_out(dout), .o_data_oe(oe), .i_data_in(wire_v));

  eprom_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVC)) model_u (
    .i_pins(pins), .i_hdata(dout), .i_hoe(oe), .o_wire(wire_v));

  // Compare and tally
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One request, waits for done under a bound; called at a falling edge
  task automatic run_op(input op_t op, input logic [13:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    valid = 1'b1;
    cmd = '{op: op, addr: a, data: d};
    // Ready looked at on falling edges, where it has settled
    while (ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) check(32'h0, 32'h1);
  endtask

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // Pin watcher on every falling edge
  always @(negedge clk) begin
    if (pins.id_high_voltage_level === 1'b1)
      check(32'(pins.addr[13:1]), 32'h0);
    if (pins.program_strobe_n === 1'b0)
      check({pins.dev_select_n, pins.out_gate_n, pins.vpp_prog, oe},
            32'h7);
    if (pins.out_gate_n === 1'b0) check(32'(oe), 32'h0);
    if (!pins.dev_select_n && !pins.out_gate_n && pins.vpp_prog) ver_n++;
  end

  // Main sequence
  initial begin
    mismatches = 0;
    total_checks = 0;
    ver_n = 0;
    rst = 1'b1;
    valid = 1'b0;
    cmd = '0;
    repeat (6) @(negedge clk);
    check(pins, PINS_STANDBY);
    check({ready, oe, rdata}, 32'h200);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      run_op(ROWS[i].op, ROWS[i].a, ROWS[i].d);
      check(rdata, ROWS[i].rd);
      check(blank, ROWS[i].blank);
      check(par, ^ROWS[i].rd);
      if (ROWS[i].op == OP_PROGRAM) begin
        check(vok, ROWS[i].vok);
        check(stuck, ROWS[i].stuck);
      end
    end
    check(32'(ver_n != 0), 32'h1);
    // A request while busy is ignored
    fork
      run_op(OP_READ, 14'h0005, 8'h00);
      begin
        repeat (5) @(negedge clk);
        valid = 1'b1;
        cmd = '{op: OP_PROGRAM, addr: 14'h0005, data: 8'h00};
        repeat (5) @(negedge clk);
        valid = 1'b0;
      end
    join
    check(rdata, 8'h0a);
    run_op(OP_READ, 14'h0005, 8'h00);
    check(rdata, 8'h0a);
    // Reset in mid-program leaves the cell and the pins safe
    valid = 1'b1;
    cmd = '{op: OP_PROGRAM, addr: 14'h0005, data: 8'h00};
    @(negedge clk);
    valid = 1'b0;
    // Land inside the strobe-low stretch of the pulse
    repeat (25) @(negedge clk);
    check(32'(pins.program_strobe_n), 32'h0);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check(pins, PINS_STANDBY);
    check({ready, done, oe}, 32'h4);
    rst = 1'b0;
    @(negedge clk);
    run_op(OP_READ, 14'h0005, 8'h00);
    check(rdata, 8'h0a);
    finish_test();
  end
endmodule // testbench
